// ---- hdl/msqd_db_conv.sv ----
// Sum-of-squares to decibels (no square root) and binary to BCD conversion
`timescale 1ns/1ns
`default_nettype none
module msqd_db_conv (
	input  wire logic [14:0] sum_mant,
	input  wire logic [5:0]  sum_exp,
	input  wire logic [10:0] db_sum,
	input  wire logic [7:0]  range_ofs,
	input  wire logic        ovl_in,
	output logic      [3:0]  mant_q,
	output logic      [10:0] exp_q,
	output logic             ovl,
	output logic      [9:0]  level_q,
	output logic      [11:0] bcd
);
	logic [3:0]  pos;
	logic [14:0] norm;
	logic [6:0]  n;
	logic [20:0] prod;
	logic [10:0] rel;
	logic [8:0]  whole;
	logic [11:0] d;

	assign pos  = msqd_pkg::lead_pos(sum_mant);
	assign norm = sum_mant << (4'he - pos);
	assign n    = 7'(sum_exp) + 7'(pos);
	assign prod = 21'(n) * 21'(msqd_pkg::EXP_DB_K);
	assign ovl  = (sum_exp > msqd_pkg::EXP_OVL);

	// Mantissa part: mantissa_decibel_lookup from the three bits below the leading one
	always_comb begin
		case (norm[13:11])
			3'h0: mant_q = 4'h0;
			3'h1: mant_q = 4'h2;
			3'h2: mant_q = 4'h4;
			3'h3: mant_q = 4'h5;
			3'h4: mant_q = 4'h7;
			3'h5: mant_q = 4'h8;
			3'h6: mant_q = 4'h9;
			default: mant_q = 4'hb;
		endcase
	end
	// Exponent part: power of two times 3.01 dB; empty sums give nothing
	assign exp_q = (sum_mant == 15'h0000) ? 11'h000 : prod[20:10];

	// Reference shift, clamped at zero; the analog level never carries the range offset
	assign rel     = (db_sum > msqd_pkg::DB_REF_Q) ? (db_sum - msqd_pkg::DB_REF_Q) : 11'h000;
	assign level_q = (rel > 11'h3ff) ? 10'h3ff : rel[9:0];
	assign whole   = 9'(level_q[9:2]) + 9'(range_ofs);

	// Double dabble to 1-2-4-8 digits
	always_comb begin
		d = 12'h000;
		for (int i = 8; i >= 0; i--) begin
			if (d[3:0] > 4'h4) d[3:0] = d[3:0] + 4'h3;
			if (d[7:4] > 4'h4) d[7:4] = d[7:4] + 4'h3;
			if (d[11:8] > 4'h4) d[11:8] = d[11:8] + 4'h3;
			d = {d[10:0], whole[i]};
		end
		// Overload shows as 800-some or 900-some
		if (ovl_in)
			bcd = {(d[11:8] != 4'h0) ? 4'h9 : 4'h8, d[7:0]};
		else
			bcd = d;
	end
endmodule
`default_nettype wire

// ---- hdl/msqd_detector.sv ----
// Multichannel sum-of-squares detector core with APB register slave
//
// Chosen here: the address map and the APB interface to the registers.
`timescale 1ns/1ns
`default_nettype none
module msqd_detector #(
	parameter int unsigned BAND_CYC  = msqd_pkg::BAND_CYC,
	parameter int unsigned REC_CYC   = msqd_pkg::REC_CYC,
	parameter int unsigned PASSES_1S = msqd_pkg::PASSES_1S
) (
	input  wire logic                     pclk,
	input  wire logic                     presetn,
	input  wire logic                     psel,
	input  wire logic                     penable,
	input  wire logic                     pwrite,
	input  wire logic [7:0]               paddr,
	input  wire logic [31:0]              pwdata,
	output logic      [31:0]              prdata,
	output logic                          pready,
	output logic                          pslverr,
	input  wire logic signed [msqd_pkg::SMP_W-1:0] smp_hi,
	input  wire logic signed [msqd_pkg::SMP_W-1:0] smp_lo,
	output logic      [2:0]               mux_row,
	output logic      [2:0]               mux_col,
	output logic                          hold_take,
	output logic      [11:0]              band_bcd,
	output logic      [9:0]               band_level,
	output logic      [5:0]               band_chan,
	output logic                          band_stb,
	output logic      [11:0]              disp_bcd,
	output logic      [9:0]               disp_level,
	output logic                          disp_stb
);
	typedef enum {
		S_IDLE, S_CLR, S_HOLD, S_WAITC, S_LOAD, S_CMP, S_ALIGN, S_ADD, S_NORM, S_WB,
		S_ORD, S_OSPLIT, S_OSUM, S_OEMIT, S_OPACE
	} msqd_state_t;

	msqd_state_t state_r;
	msqd_sq_if   sq ();

	// Control and configuration
	logic [1:0]  itime_r;
	logic [2:0]  mode_r;
	logic [5:0]  last_ch_r;
	logic [7:0]  range_ofs_r;
	logic [7:0]  disp_rate_r;
	logic        done_r;
	logic        ovl_seen_r;
	// Datapath
	logic [20:0] mem_r [msqd_pkg::NUM_ADDR];
	logic [15:0] acc_m_r;
	logic [5:0]  acc_e_r;
	logic [14:0] buf_m_r;
	logic [5:0]  buf_e_r;
	logic [5:0]  ch_r;
	logic [10:0] pass_r;
	logic [16:0] wait_r;
	logic        ovl_r;
	// Results
	logic [11:0] bcd_r;
	logic [9:0]  level_r;
	logic [24:0] disp_cnt_r;
	logic signed [msqd_pkg::SMP_W-1:0] hi_r;
	logic signed [msqd_pkg::SMP_W-1:0] lo_r;

	logic        wr_en;
	logic        rd_en;
	logic        start_meas;
	logic        start_out;
	logic        clr_done;
	logic        print_mode;
	logic [10:0] passes;
	logic [5:0]  scaled_e;
	logic [3:0]  mant_q;
	logic [10:0] exp_q;
	logic        ovl_now;
	logic [9:0]  level_now;
	logic [11:0] bcd_now;
	logic [24:0] disp_period;

	// APB slave: zero wait states, single-cycle access phase
	assign pready     = 1'b1;
	assign wr_en      = psel && penable && pwrite;
	assign rd_en      = psel && penable && !pwrite;
	assign start_meas = wr_en && (paddr == msqd_pkg::OFS_CTRL) && pwdata[msqd_pkg::CTRL_MEAS];
	assign start_out  = wr_en && (paddr == msqd_pkg::OFS_CTRL) && pwdata[msqd_pkg::CTRL_OUT];
	assign clr_done   = wr_en && (paddr == msqd_pkg::OFS_STATUS) && pwdata[2];
	assign print_mode = (mode_r == 3'(msqd_pkg::MSQD_XY_PLOT))
		|| (mode_r == 3'(msqd_pkg::MSQD_PRINTER));

	// Unmapped addresses answer with an error and zero data
	always_comb begin
		prdata  = 32'h0000_0000;
		pslverr = 1'b0;
		case (paddr)
			msqd_pkg::OFS_CTRL:
				prdata = {25'h0, mode_r, itime_r, 2'b00};
			msqd_pkg::OFS_CONFIG:
				prdata = {8'h00, disp_rate_r, range_ofs_r, 2'b00, last_ch_r};
			msqd_pkg::OFS_STATUS:
				prdata = {28'h0, ovl_seen_r, done_r,
					(state_r >= S_ORD), (state_r != S_IDLE) && (state_r < S_ORD)};
			msqd_pkg::OFS_RESULT:
				prdata = {4'h0, level_r, ch_r, bcd_r};
			default:
				pslverr = psel && penable;
		endcase
	end

	// Configuration registers, only written while the core is idle
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			itime_r     <= 2'b00;
			mode_r      <= 3'b000;
			last_ch_r   <= msqd_pkg::RST_LAST;
			range_ofs_r <= 8'h00;
			disp_rate_r <= msqd_pkg::RST_DR;
		end else if (wr_en && state_r == S_IDLE) begin
			if (paddr == msqd_pkg::OFS_CTRL) begin
				itime_r <= pwdata[msqd_pkg::CTRL_IT_LO +: 2];
				mode_r  <= pwdata[msqd_pkg::CTRL_MD_LO +: 3];
			end
			if (paddr == msqd_pkg::OFS_CONFIG) begin
				last_ch_r   <= pwdata[msqd_pkg::CFG_LAST_LO +: 6];
				range_ofs_r <= pwdata[msqd_pkg::CFG_OFS_LO +: 8];
				disp_rate_r <= pwdata[msqd_pkg::CFG_DR_LO +: 8];
			end
		end
	end

	// Done and overload flags: hardware set beats software clear
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			done_r     <= 1'b0;
			ovl_seen_r <= 1'b0;
		end else begin
			if (state_r == S_OPACE && wait_r == 17'h0 && ch_r == last_ch_r)
				done_r <= 1'b1;
			else if (clr_done)
				done_r <= 1'b0;
			if (state_r == S_OEMIT && ovl_r)
				ovl_seen_r <= 1'b1;
			else if (clr_done)
				ovl_seen_r <= 1'b0;
		end
	end

	assign passes = 11'(PASSES_1S) >> itime_r;
	// Multiply by 2, 4 or 8 through the exponent
	assign scaled_e = buf_e_r + 6'(itime_r);

	// Matrix address, calibration inputs sit above 44
	// Addresses 46 and 47 reach the calibration inputs
	assign mux_row = 3'(ch_r / 6'(msqd_pkg::MUX_COLS));
	assign mux_col = 3'(ch_r % 6'(msqd_pkg::MUX_COLS));
	assign hold_take = (state_r == S_HOLD);

	// Held samples go to the squarer only after the coarse decision settles
	assign sq.smp_hi = hi_r;
	assign sq.smp_lo = lo_r;
	// Polarity and squaring done in the converter
	// Square returned as mantissa and exponent
	msqd_squarer u_sq (
		.sq (sq)
	);

	// Decibel parts from mantissa and exponent
	msqd_db_conv u_db (
		.sum_mant  (buf_m_r),
		.sum_exp   (scaled_e),
		.db_sum    (acc_m_r[10:0]),
		.range_ofs (range_ofs_r),
		.ovl_in    (ovl_r),
		.mant_q    (mant_q),
		.exp_q     (exp_q),
		.ovl       (ovl_now),
		.level_q   (level_now),
		.bcd       (bcd_now)
	);

	// Sequencer: gather phase or output phase, each started from idle
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			state_r <= S_IDLE;
			ch_r    <= 6'h00;
			pass_r  <= 11'h000;
			wait_r  <= 17'h0;
		end else begin
			case (state_r)
				S_IDLE: begin
					ch_r   <= 6'h00;
					pass_r <= 11'h000;
					if (start_meas)
						state_r <= S_CLR;
					else if (start_out)
						state_r <= S_ORD;
				end
				S_CLR:
					state_r <= S_HOLD;
				S_HOLD: begin
					wait_r  <= 17'(msqd_pkg::COARSE_CYC - 1);
					state_r <= S_WAITC;
				end
				S_WAITC: begin
					if (wait_r == 17'h0)
						state_r <= S_LOAD;
					else
						wait_r <= wait_r - 17'h1;
				end
				S_LOAD:
					state_r <= S_CMP;
				S_CMP:
					state_r <= S_ALIGN;
				S_ALIGN: begin
					if (acc_e_r == buf_e_r)
						state_r <= S_ADD;
				end
				S_ADD:
					state_r <= S_NORM;
				S_NORM:
					state_r <= S_WB;
				// Next channel, next scan, or finished
				S_WB: begin
					state_r <= S_HOLD;
					if (ch_r == last_ch_r) begin
						ch_r <= 6'h00;
						if (pass_r == passes - 11'h1)
							state_r <= S_IDLE;
						else
							pass_r <= pass_r + 11'h1;
					end else begin
						ch_r <= ch_r + 6'h01;
					end
				end
				S_ORD:
					state_r <= S_OSPLIT;
				S_OSPLIT:
					state_r <= S_OSUM;
				S_OSUM:
					state_r <= S_OEMIT;
				// Scope modes pace one band per ms
				// Recorder and printer pace at 360 per s
				S_OEMIT: begin
					wait_r  <= print_mode ? 17'(REC_CYC - 1) : 17'(BAND_CYC - 1);
					state_r <= S_OPACE;
				end
				S_OPACE: begin
					if (wait_r != 17'h0) begin
						wait_r <= wait_r - 17'h1;
					end else if (ch_r == last_ch_r) begin
						state_r <= S_IDLE;
					end else begin
						ch_r    <= ch_r + 6'h01;
						state_r <= S_ORD;
					end
				end
				default:
					state_r <= S_IDLE;
			endcase
		end
	end

	// Both samples are captured together when the coarse wait ends
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			hi_r <= '0;
			lo_r <= '0;
		end else if (state_r == S_WAITC && wait_r == 17'h0) begin
			hi_r <= smp_hi;
			lo_r <= smp_lo;
		end
	end

	// Accumulator and memory buffer
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			acc_m_r <= 16'h0000;
			acc_e_r <= 6'h00;
			buf_m_r <= 15'h0000;
			buf_e_r <= 6'h00;
			ovl_r   <= 1'b0;
		end else begin
			case (state_r)
				// Square and stored sum load together
				S_LOAD: begin
					acc_m_r <= {1'b0, sq.sq_mant};
					acc_e_r <= sq.sq_exp;
					{buf_m_r, buf_e_r} <= mem_r[ch_r];
				end
				// Smaller exponent must sit in accumulator
				S_CMP: begin
					if (buf_e_r < acc_e_r) begin
						acc_m_r <= {1'b0, buf_m_r};
						acc_e_r <= buf_e_r;
						buf_m_r <= acc_m_r[14:0];
						buf_e_r <= acc_e_r;
					end
				end
				// One place per cycle until aligned
				S_ALIGN: begin
					if (acc_e_r != buf_e_r) begin
						acc_m_r <= acc_m_r >> 1;
						acc_e_r <= acc_e_r + 6'h01;
					end
				end
				S_ADD:
					acc_m_r <= acc_m_r + {1'b0, buf_m_r};
				// Carry into bit 15 costs one shift
				S_NORM: begin
					if (acc_m_r[15]) begin
						acc_m_r <= acc_m_r >> 1;
						acc_e_r <= acc_e_r + 6'h01;
					end
				end
				S_ORD:
					{buf_m_r, buf_e_r} <= mem_r[ch_r];
				// Both decibel parts loaded at once
				S_OSPLIT: begin
					buf_m_r <= {11'h000, mant_q};
					buf_e_r <= 6'h00;
					acc_m_r <= {5'h00, exp_q};
					ovl_r   <= ovl_now;
				end
				S_OSUM:
					acc_m_r <= acc_m_r + {1'b0, buf_m_r};
				default: begin
				end
			endcase
		end
	end

	// Channel memory: cleared per measurement, written after each add
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			for (int i = 0; i < msqd_pkg::NUM_ADDR; i++)
				mem_r[i] <= 21'h0;
		end else if (state_r == S_CLR) begin
			for (int i = 0; i < msqd_pkg::NUM_ADDR; i++)
				mem_r[i] <= 21'h0;
		end else if (state_r == S_WB) begin
			mem_r[ch_r] <= {acc_m_r[14:0], acc_e_r};
		end else if (state_r == S_OSPLIT) begin
			mem_r[ch_r] <= {buf_m_r, buf_e_r};
		end
	end

	// Band results for recorder, printer and scope
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			bcd_r      <= 12'h000;
			level_r    <= 10'h000;
			band_bcd   <= 12'h000;
			band_level <= 10'h000;
			band_chan  <= 6'h00;
			band_stb   <= 1'b0;
		end else begin
			band_stb <= (state_r == S_OEMIT);
			if (state_r == S_OEMIT) begin
				// Range offset included in the digits
				bcd_r      <= bcd_now;
				level_r    <= level_now;
				band_bcd   <= bcd_now;
				band_level <= level_now;
				band_chan  <= ch_r;
			end
		end
	end

	// Display feed: follows every band in scope modes, own rate otherwise
	assign disp_period = 25'(disp_rate_r) * 25'(BAND_CYC);
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			disp_cnt_r <= 25'h0;
			disp_bcd   <= 12'h000;
			disp_level <= 10'h000;
			disp_stb   <= 1'b0;
		end else begin
			disp_stb <= 1'b0;
			if (!print_mode) begin
				disp_cnt_r <= 25'h0;
				if (state_r == S_OEMIT) begin
					disp_stb   <= 1'b1;
					disp_bcd   <= bcd_now;
					disp_level <= level_now;
				end
			end else if (disp_cnt_r >= disp_period) begin
				disp_cnt_r <= 25'h0;
				disp_stb   <= 1'b1;
				disp_bcd   <= bcd_r;
				disp_level <= level_r;
			end else begin
				disp_cnt_r <= disp_cnt_r + 25'h1;
			end
		end
	end
endmodule
`default_nettype wire

// ---- hdl/msqd_pkg.sv ----
// Shared constants, register map and helper functions for the sum-of-squares detector
package msqd_pkg;
	// Clock and timing
	localparam int unsigned CLK_HZ        = 20_000_000;
	localparam int unsigned COARSE_NS     = 1000;          // Coarse-range decision delay
	localparam int unsigned COARSE_CYC    = (COARSE_NS * (CLK_HZ / 1_000_000) + 999) / 1000;
	localparam int unsigned BAND_US       = 1000;          // Scope modes: one band per ms
	localparam int unsigned BAND_CYC      = BAND_US * (CLK_HZ / 1_000_000);
	localparam int unsigned MAX_BAND_RATE = 360;           // Bands per second, recorder/printer
	localparam int unsigned REC_CYC       = (CLK_HZ + MAX_BAND_RATE - 1) / MAX_BAND_RATE;
	localparam int unsigned PASSES_1S     = 1024;          // Scans per channel in 1 s

	// Multiplexer geometry: 8 rows by 6 columns
	localparam int unsigned MUX_COLS    = 6;
	localparam int unsigned NUM_CHAN    = 45;
	localparam logic [5:0]  CH_UNUSED   = 6'h2d;
	localparam logic [5:0]  CH_ZERO_CAL = 6'h2e;           // Grounded input
	localparam logic [5:0]  CH_FS_CAL   = 6'h2f;           // Precise dc, 60 dB full scale
	localparam int unsigned NUM_ADDR    = 48;

	// Number formats
	localparam int unsigned SMP_W   = 12;                  // Signed sample width
	localparam int unsigned MANT_W  = 15;
	localparam int unsigned EXP_W   = 6;
	localparam int unsigned GAIN_SH = 7;                   // Coarse range gain ratio, 2^7
	localparam logic [10:0] SAT_MAG = 11'h7ff;

	// Decibel conversion, quarter-dB units
	localparam logic [13:0] EXP_DB_K = 14'h3029;           // 3.01 dB * 4 * 1024
	localparam logic [10:0] DB_REF_Q = 11'h0b0;
	localparam logic [5:0]  EXP_OVL  = 6'h2a;              // Largest in-range exponent

	// APB register map
	localparam logic [7:0] OFS_CTRL   = 8'h00;
	localparam logic [7:0] OFS_CONFIG = 8'h04;
	localparam logic [7:0] OFS_STATUS = 8'h08;
	localparam logic [7:0] OFS_RESULT = 8'h0c;

	// CTRL fields
	localparam int unsigned CTRL_MEAS  = 0;
	localparam int unsigned CTRL_OUT   = 1;
	localparam int unsigned CTRL_IT_LO = 2;
	localparam int unsigned CTRL_MD_LO = 4;
	// CONFIG fields
	localparam int unsigned CFG_LAST_LO = 0;
	localparam int unsigned CFG_OFS_LO  = 8;
	localparam int unsigned CFG_DR_LO   = 16;
	// Reset values
	localparam logic [5:0] RST_LAST = 6'h2c;
	localparam logic [7:0] RST_DR   = 8'h0a;

	// Display / output modes
	typedef enum logic [2:0] {
		MSQD_LIVE, MSQD_STORE_ERASE, MSQD_STORE_KEEP, MSQD_XY_PLOT, MSQD_PRINTER
	} msqd_mode_t;

	// Position of the leading one of a 15-bit value
	function automatic logic [3:0] lead_pos(input logic [14:0] v);
		lead_pos = 4'h0;
		for (int i = 0; i < 15; i++) begin
			if (v[i])
				lead_pos = 4'(i);
		end
	endfunction
endpackage

// ---- hdl/msqd_sq_if.sv ----
// Carrier between the sample squarer and the detector core
`timescale 1ns/1ns
`default_nettype none
interface msqd_sq_if;
	logic signed [msqd_pkg::SMP_W-1:0]  smp_hi;   // High-gain sample
	logic signed [msqd_pkg::SMP_W-1:0]  smp_lo;   // Low-gain sample
	logic        [msqd_pkg::MANT_W-1:0] sq_mant;
	logic        [msqd_pkg::EXP_W-1:0]  sq_exp;
	logic                               coarse;   // Low-gain sample chosen

	modport conv (input smp_hi, input smp_lo, output sq_mant, output sq_exp, output coarse);
	modport core (output smp_hi, output smp_lo, input sq_mant, input sq_exp, input coarse);
endinterface
`default_nettype wire

// ---- hdl/msqd_squarer.sv ----
// Coarse/fine floating-point conversion and squaring of one held sample pair
`timescale 1ns/1ns
`default_nettype none
module msqd_squarer (
	msqd_sq_if.conv sq
);
	logic [10:0] mag_hi;
	logic [10:0] mag_lo;
	logic [10:0] mag;
	logic [3:0]  pos;
	logic [3:0]  m4;
	logic [14:0] wide;

	// Polarity inversion so the converter only sees positive magnitudes
	always_comb begin
		mag_hi = sq.smp_hi[11] ? 11'((~sq.smp_hi) + 12'h001) : sq.smp_hi[10:0];
		mag_lo = sq.smp_lo[11] ? 11'((~sq.smp_lo) + 12'h001) : sq.smp_lo[10:0];
	end

	// Coarse range: high gain unless it sits at its limit
	assign sq.coarse = (mag_hi >= msqd_pkg::SAT_MAG);
	assign mag       = sq.coarse ? mag_lo : mag_hi;

	// Fine range finds the 2:1 group, then three more bits form the mantissa
	assign wide = {4'h0, mag};
	assign pos  = msqd_pkg::lead_pos(wide);
	always_comb begin
		if (pos >= 4'h3)
			m4 = 4'(mag >> (pos - 4'h3));
		else
			m4 = 4'(mag << (4'h3 - pos));
	end

	// Square: mantissa squared, exponent doubled, zero stays zero
	always_comb begin
		if (mag == 11'h000) begin
			sq.sq_mant = 15'h0000;
			sq.sq_exp  = 6'h00;
		end else begin
			sq.sq_mant = {7'h00, 8'(m4 * m4)};
			sq.sq_exp  = 6'({1'b0, pos} + (sq.coarse ? 5'(msqd_pkg::GAIN_SH) : 5'h00)) << 1;
		end
	end
endmodule
`default_nettype wire

// ---- test/msqd_detector_checker.sv ----
// Port-level assertions for the sum-of-squares detector
`timescale 1ns/1ns
`default_nettype none
module msqd_detector_checker (
	input wire logic        pclk,
	input wire logic        presetn,
	input wire logic        psel,
	input wire logic        penable,
	input wire logic [31:0] prdata,
	input wire logic        pslverr,
	input wire logic [2:0]  mux_row,
	input wire logic [2:0]  mux_col,
	input wire logic        hold_take,
	input wire logic [11:0] band_bcd,
	input wire logic [9:0]  band_level,
	input wire logic        band_stb,
	input wire logic        disp_stb
);
	default clocking @(posedge pclk); endclocking
	default disable iff (!presetn);

	mux_col_range_a: assert property (mux_col <= 3'h5)
		else $error("mux column out of range");
	hold_single_a: assert property (hold_take |=> !hold_take [*8])
		else $error("hold pulse too long or too close");
	mux_addr_held_a: assert property (hold_take |=> $stable({mux_row, mux_col}) [*8])
		else $error("mux address moved during hold");
	err_phase_a: assert property (pslverr |-> psel && penable && prdata == 32'h0)
		else $error("error response outside access or with data");
	bcd_digits_a: assert property (band_stb |-> band_bcd[7:4] <= 4'h9 && band_bcd[3:0] <= 4'h9)
		else $error("bad decimal digit");
	band_spacing_a: assert property (band_stb |=> !band_stb [*8])
		else $error("band strobes too close");
	disp_pulse_a: assert property (disp_stb |=> !disp_stb)
		else $error("display strobe too long");
	level_with_stb_a: assert property ($changed(band_level) |-> band_stb)
		else $error("level changed without strobe");
	hundreds_code_a: assert property (band_stb |-> band_bcd[11:8] <= 4'h3 || band_bcd[11:8] >= 4'h8)
		else $error("hundreds digit neither range nor overload");

	cover property (hold_take);
	cover property (band_stb);
	cover property (disp_stb);
endmodule

bind msqd_detector msqd_detector_checker chk_i (
	.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .prdata(prdata),
	.pslverr(pslverr), .mux_row(mux_row), .mux_col(mux_col), .hold_take(hold_take),
	.band_bcd(band_bcd), .band_level(band_level), .band_stb(band_stb), .disp_stb(disp_stb)
);
`default_nettype wire

// ---- test/msqd_front_model.sv ----
// Filter bank and dual-gain sample-hold model feeding the detector
`timescale 1ns/1ns
`default_nettype none
module msqd_front_model (
	input  wire logic                              pclk,
	input  wire logic                              presetn,
	input  wire logic                              hold_take,
	input  wire logic [2:0]                        mux_row,
	input  wire logic [2:0]                        mux_col,
	output logic signed [msqd_pkg::SMP_W-1:0]      smp_hi,
	output logic signed [msqd_pkg::SMP_W-1:0]      smp_lo
);
	int   amp;
	int   sat;
	logic neg_r;

	// Steady tone per channel; grounded calibration inputs give zero
	// channel levels
	always_comb begin
		amp = (int'(mux_row) * 6 + int'(mux_col) + 1) * 900;
		if (int'(mux_row) * 6 + int'(mux_col) >= 45)
			amp = 0;
		sat = (amp > 2047) ? 2047 : amp;
	end

	// Both gains taken together; sign alternates so inversion is exercised
	// dual samples
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			neg_r  <= 1'b0;
			smp_hi <= 12'h000;
			smp_lo <= 12'h000;
		end else if (hold_take) begin
			neg_r  <= ~neg_r;
			smp_hi <= neg_r ? 12'(-sat) : 12'(sat);
			smp_lo <= neg_r ? 12'(-(amp / 128)) : 12'(amp / 128);
		end
	end
endmodule
`default_nettype wire

// ---- test/tb_multichannel_sum_squares_db_detector.sv ----
// Self-checking bench: APB tasks, measurement and output passes
`timescale 1ns/1ns
`default_nettype none
module tb_multichannel_sum_squares_db_detector;
	logic        pclk = 1'b0;
	logic        presetn = 1'b0;
	logic        psel = 1'b0;
	logic        penable = 1'b0;
	logic        pwrite = 1'b0;
	logic [7:0]  paddr = 8'h00;
	logic [31:0] pwdata = 32'h0;
	logic [31:0] prdata;
	logic        pready;
	logic        pslverr;
	logic signed [11:0] smp_hi;
	logic signed [11:0] smp_lo;
	logic [2:0]  mux_row;
	logic [2:0]  mux_col;
	logic        hold_take;
	logic [11:0] band_bcd;
	logic [9:0]  band_level;
	logic [5:0]  band_chan;
	logic        band_stb;
	logic        disp_stb;
	logic [11:0] disp_bcd;
	logic [9:0]  disp_level;
	logic [31:0] rd;
	logic        se;
	logic [11:0] bcd_q[8];
	logic [9:0]  lvl_q[8];
	logic [9:0]  lvl0[8];
	logic [31:0] dec0[8];
	int          nb = 0;
	int          err_count = 0;
	int          comparisons = 0;

	always #25 pclk = ~pclk;

	// Short pacing counts keep the run small
	msqd_detector #(.BAND_CYC(20), .REC_CYC(40), .PASSES_1S(2)) uut (
		.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
		.paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
		.smp_hi(smp_hi), .smp_lo(smp_lo), .mux_row(mux_row), .mux_col(mux_col),
		.hold_take(hold_take), .band_bcd(band_bcd), .band_level(band_level),
		.band_chan(band_chan), .band_stb(band_stb), .disp_bcd(disp_bcd), .disp_level(disp_level),
		.disp_stb(disp_stb)
	);

	msqd_front_model fe (
		.pclk(pclk), .presetn(presetn), .hold_take(hold_take), .mux_row(mux_row),
		.mux_col(mux_col), .smp_hi(smp_hi), .smp_lo(smp_lo)
	);

	task automatic chk(input string nm, input logic [31:0] ex, input logic [31:0] got);
		comparisons++;
		if (got !== ex) begin
			err_count++;
			$display("BAD %s expected %h seen %h", nm, ex, got);
		end
	endtask

	function automatic logic [31:0] dec(input logic [11:0] b);
		return 32'(b[11:8]) * 100 + 32'(b[7:4]) * 10 + 32'(b[3:0]);
	endfunction

	task automatic end_sim();
		$display("errors %0d comparisons %0d", err_count, comparisons);
		if (err_count == 0 && comparisons > 0)
			$display("DONE - PASS");
		else
			$display("DONE - FAIL");
		$finish;
	endtask

	// One APB transfer; held until pready is seen at a rising edge
	task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
		@(posedge pclk);
		psel    <= 1'b1;
		penable <= 1'b0;
		pwrite  <= w;
		paddr   <= a;
		pwdata  <= d;
		@(posedge pclk);
		penable <= 1'b1;
		// Only the watchdog ends a wait that never sees pready
		do begin
			@(posedge pclk);
		end while (pready !== 1'b1);
		rd      = prdata;
		se      = pslverr;
		psel    <= 1'b0;
		penable <= 1'b0;
	endtask

	// Write a control word, then poll until both busy flags clear
	task automatic run(input logic [31:0] c);
		int n;
		n  = 0;
		nb = 0;
		apb(1'b1, 8'h00, c);
		do begin
			apb(1'b0, 8'h08, 32'h0);
			n++;
		end while (rd[1:0] !== 2'b00 && n < 3000);
		chk("idle", 32'h0, {30'h0, rd[1:0]});
	endtask

	// Band results collected in arrival order
	always @(posedge pclk) begin
		if (band_stb === 1'b1 && nb < 8) begin
			chk("band_chan", 32'(nb), {26'h0, band_chan});
			bcd_q[nb] = band_bcd;
			lvl_q[nb] = band_level;
			nb++;
		end
	end

	initial begin
		repeat (10) @(posedge pclk);
		presetn <= 1'b1;
		apb(1'b0, 8'h04, 32'h0);
		chk("config_rst", 32'h000a002c, rd);
		apb(1'b0, 8'h00, 32'h0);
		chk("ctrl_rst", 32'h0, rd);
		apb(1'b0, 8'h10, 32'h0);
		chk("unmapped_err", 32'h1, {31'h0, se});
		chk("unmapped_data", 32'h0, rd);
		apb(1'b1, 8'h04, 32'h000a_0002);
		apb(1'b0, 8'h04, 32'h0);
		chk("config_wr", 32'h000a0002, rd);
		// Gather at 1 s, then output three bands in a scope mode
		run(32'h1);
		run(32'h2);
		chk("band_count", 32'h3, 32'(nb));
		for (int i = 0; i < 3; i++) begin
			lvl0[i] = lvl_q[i];
			dec0[i] = dec(bcd_q[i]);
			chk("bcd_vs_level", 32'(lvl_q[i] / 4), dec0[i]);
		end
		// Doubled amplitude reads 6 dB (24 quarter steps) higher; scope display tracks bands
		chk("level_6db", 32'd24, 32'(lvl_q[1]) - 32'(lvl_q[0]));
		chk("disp_bcd", 32'(bcd_q[2]), 32'(disp_bcd));
		chk("disp_level", 32'(lvl_q[2]), 32'(disp_level));
		apb(1'b0, 8'h0c, 32'h0);
		chk("result", {4'h0, lvl_q[2], 6'h00, bcd_q[2]}, rd);
		apb(1'b1, 8'h08, 32'h4);
		apb(1'b0, 8'h08, 32'h0);
		chk("done_clr", 32'h0, {31'h0, rd[2]});
		// Range offset of 20 dB; display rate kept so plot-mode strobes stay apart
		apb(1'b1, 8'h04, 32'h000a_1402);
		run(32'h2);
		for (int i = 0; i < 3; i++) begin
			chk("level_ofs", 32'(lvl0[i]), 32'(lvl_q[i]));
			chk("bcd_ofs", dec0[i] + 32'd20, dec(bcd_q[i]));
		end
		// Half-second gather in plot mode: scaled result matches, sums start clean
		run(32'h35);
		apb(1'b0, 8'h00, 32'h0);
		chk("ctrl_rd", 32'h34, rd);
		run(32'h36);
		for (int i = 0; i < 3; i++)
			chk("level_itime", 32'(lvl0[i]), 32'(lvl_q[i]));
		end_sim();
	end

	// Hang guard well above the expected several hundred cycles
	initial begin
		repeat (40000) @(posedge pclk);
		err_count++;
		end_sim();
	end
endmodule
`default_nettype wire
